/* File: pkg/fma_pkg.sv */
// constants and types shared by the float-mode ambient monitor
package fma_pkg;

  // register addresses as printed for the serial register port
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_THR_A  = 8'h16;
  localparam logic [7:0] ADDR_THR_B  = 8'h1c;
  localparam logic [7:0] ADDR_LED_A  = 8'h3e;

  // field positions
  localparam int CNT_SEL_MSB = 15;
  localparam int CNT_SEL_LSB = 14;
  localparam int THR_MSB     = 13;
  localparam int LED_SEL_MSB = 15;
  localparam int LED_SEL_LSB = 14;
  localparam int WIDTH_MSB   = 12;
  localparam int WIDTH_LSB   = 8;
  localparam int OFFSET_MSB  = 7;
  localparam int SLOT_CHANS  = 4;

  // values after reset
  localparam logic [15:0] THR_RST     = 16'h0000;
  localparam logic [15:0] LED_CFG_RST = 16'h0320;
  localparam logic [7:0]  FLAGS_RST   = 8'h00;

  // exceedance targets for count codes 1, 2 and 3
  localparam logic [4:0] HITS_ONE     = 5'h01;
  localparam logic [4:0] HITS_FOUR    = 5'h04;
  localparam logic [4:0] HITS_SIXTEEN = 5'h10;

  // led timing: one step of width and delay in clock cycles
  localparam int CLK_PERIOD_NS = 10;
  localparam int LED_STEP_NS   = 1000;
  localparam int STEP_CYCLES   = LED_STEP_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    FMA_IDLE  = 2'b00,
    FMA_DELAY = 2'b01,
    FMA_PULSE = 2'b10
  } fma_led_state_t;

endpackage

/* File: core/fma_chan.sv */
// one channel: exceedance counter and sticky clear-on-read flag
module fma_chan (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       hit,
  input  wire logic       clr,
  input  wire logic [1:0] count_sel,
  output logic            flag
);

  logic [4:0] cnt_r;
  logic [4:0] cnt_base;
  logic [4:0] cnt_nxt;
  logic [4:0] target;
  logic       flag_r;
  logic       flag_nxt;

  // count code to number of exceedances
  always_comb
  begin
    case (count_sel)
      2'h1:    target = fma_pkg::HITS_ONE;
      2'h2:    target = fma_pkg::HITS_FOUR;
      2'h3:    target = fma_pkg::HITS_SIXTEEN;
      default: target = 5'h00;
    endcase
  end

  // a clear restarts counting, a hit in the same cycle still counts
  always_comb
  begin
    cnt_base = clr ? 5'h00 : cnt_r;
    cnt_nxt  = (hit && cnt_base != fma_pkg::HITS_SIXTEEN) ? cnt_base + 5'h01 : cnt_base;
    flag_nxt = (flag_r && !clr) || (hit && target != 5'h00 && cnt_nxt >= target);
  end

  // counter and flag state
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cnt_r  <= 5'h00;
      flag_r <= 1'b0;
    end
    else
    begin
      cnt_r  <= cnt_nxt;
      flag_r <= flag_nxt;
    end
  end

  assign flag = flag_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // checks on counting and flag setting
  never_when_off_a: assert property (count_sel == 2'h0 && !flag_r |=> !flag_r)
    else $error("flag set with count code zero");
  single_hit_a: assert property (count_sel == 2'h1 && hit |=> flag_r)
    else $error("flag not set after one exceedance");
  four_hits_a: assert property ($rose(flag_r) && $past(count_sel) == 2'h2 |-> cnt_r >= 5'h04)
    else $error("flag set before four exceedances");
  sixteen_hits_a: assert property ($rose(flag_r) && $past(count_sel) == 2'h3 |-> cnt_r == 5'h10)
    else $error("flag set before sixteen exceedances");
  restart_count_a: assert property (clr && !hit |=> cnt_r == 5'h00)
    else $error("count not restarted by clear");

  sixteen_cover: cover property (count_sel == 2'h3 && $rose(flag_r));

endmodule

/* File: core/fma_top.sv */
// float-mode ambient monitor: thresholds, exceed flags and float led timing
// Function
// - in float subtract cycles, result above slot threshold bumps that channel count
// - count code 0 never flags; 1, 2, 3 flag after 1, 4, 16 exceedances
// - status bits 3:0 are slot A channels, bits 7:4 slot B channels
// - reading the status register returns flags then clears them
// - slot B has its own threshold and count code, behaves like slot A
// - slot A led choice: 0 none, 1 to 3 drive LED1 to LED3
// - slot A float pulse width in 1 us steps, reset value 0x03
// - slot A delay from slot start to first pulse, reset value 0x20
module fma_top #(
  parameter int ADC_W    = 14,
  parameter int NUM_CHAN = 4
) (
  input  wire logic        CLK,
  input  wire logic        SRST,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [15:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [15:0] REG_RDATA,
  output logic             REG_RVALID,
  input  wire logic        ADC_VALID,
  input  wire logic [13:0] ADC_RESULT,
  input  wire logic        ADC_SLOT,
  input  wire logic [1:0]  ADC_CHAN,
  input  wire logic        FLOAT_SUB,
  input  wire logic        SLOT_START,
  input  wire logic        SLOT_ID,
  output logic      [2:0]  FLOAT_LED
);

  localparam int DIV_W = $clog2(fma_pkg::STEP_CYCLES);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(fma_pkg::STEP_CYCLES - 1);
  localparam logic [15:0] STEP16 = 16'(fma_pkg::STEP_CYCLES);

  generate
    if (ADC_W != 14 || NUM_CHAN != fma_pkg::SLOT_CHANS)
    begin : g_bad_cfg
      $error("fma_top serves 14-bit results and four channels per slot only");
    end
  endgenerate

  logic [15:0]          thr_a_r;
  logic [15:0]          thr_b_r;
  logic [15:0]          led_cfg_r;
  logic [15:0]          rdata_r;
  logic                 rvalid_r;
  logic [7:0]           flags;
  logic [7:0]           hit_vec;
  logic                 status_rd;
  fma_pkg::fma_led_state_t state_r;
  logic [7:0]           us_r;
  logic [DIV_W-1:0]     div_r;
  logic                 tick;
  logic [2:0]           led_r;
  logic [1:0]           choice_q;
  logic [4:0]           width_q;
  logic [7:0]           offset_q;
  logic [1:0]           cfg_choice;
  logic [4:0]           cfg_width;
  logic [7:0]           cfg_offset;
  logic                 start_a;

  assign status_rd  = REG_RD && REG_ADDR == fma_pkg::ADDR_STATUS;
  assign cfg_choice = led_cfg_r[fma_pkg::LED_SEL_MSB:fma_pkg::LED_SEL_LSB];
  assign cfg_width  = led_cfg_r[fma_pkg::WIDTH_MSB:fma_pkg::WIDTH_LSB];
  assign cfg_offset = led_cfg_r[fma_pkg::OFFSET_MSB:0];
  assign start_a    = SLOT_START && !SLOT_ID;

  // register writes; bit 13 of the led config is stored as written
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      thr_a_r   <= fma_pkg::THR_RST;
      thr_b_r   <= fma_pkg::THR_RST;
      led_cfg_r <= fma_pkg::LED_CFG_RST;
    end
    else if (REG_WR)
    begin
      if (REG_ADDR == fma_pkg::ADDR_THR_A)
      begin
        thr_a_r <= REG_WDATA;
      end
      else if (REG_ADDR == fma_pkg::ADDR_THR_B)
      begin
        thr_b_r <= REG_WDATA;
      end
      else if (REG_ADDR == fma_pkg::ADDR_LED_A)
      begin
        led_cfg_r <= REG_WDATA;
      end
    end
  end

  // read data, one cycle after the read strobe; unmapped reads give zero
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      rdata_r  <= 16'h0000;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rvalid_r <= REG_RD;
      if (REG_RD)
      begin
        if (REG_ADDR == fma_pkg::ADDR_STATUS)
        begin
          rdata_r <= {8'h00, flags};
        end
        else if (REG_ADDR == fma_pkg::ADDR_THR_A)
        begin
          rdata_r <= thr_a_r;
        end
        else if (REG_ADDR == fma_pkg::ADDR_THR_B)
        begin
          rdata_r <= thr_b_r;
        end
        else if (REG_ADDR == fma_pkg::ADDR_LED_A)
        begin
          rdata_r <= led_cfg_r;
        end
        else
        begin
          rdata_r <= 16'h0000;
        end
      end
    end
  end

  assign REG_RDATA  = rdata_r;
  assign REG_RVALID = rvalid_r;

  // per channel compare and counter; slot A low nibble, slot B high nibble
  generate
    for (genvar i = 0; i < 2 * fma_pkg::SLOT_CHANS; i++)
    begin : g_chan
      localparam logic       IS_B = (i >= fma_pkg::SLOT_CHANS);
      localparam logic [1:0] CH   = 2'(i % fma_pkg::SLOT_CHANS);
      logic [13:0] thr;
      logic [1:0]  sel;
      assign thr = IS_B ? thr_b_r[fma_pkg::THR_MSB:0] : thr_a_r[fma_pkg::THR_MSB:0];
      assign sel = IS_B ? thr_b_r[fma_pkg::CNT_SEL_MSB:fma_pkg::CNT_SEL_LSB]
                        : thr_a_r[fma_pkg::CNT_SEL_MSB:fma_pkg::CNT_SEL_LSB];
      assign hit_vec[i] = ADC_VALID && FLOAT_SUB && ADC_SLOT == IS_B
                          && ADC_CHAN == CH && ADC_RESULT > thr;
      fma_chan u_chan (
        .clk       (CLK),
        .srst      (SRST),
        .hit       (hit_vec[i]),
        .clr       (status_rd),
        .count_sel (sel),
        .flag      (flags[i])
      );
    end
  endgenerate

  // 1 us step enable, restarted whenever a delay or pulse phase begins
  assign tick = (div_r == DIV_LAST);

  always_ff @(posedge CLK)
  begin
    if (SRST || state_r == fma_pkg::FMA_IDLE || (tick && us_r == 8'h01))
    begin
      div_r <= '0;
    end
    else if (tick)
    begin
      div_r <= '0;
    end
    else
    begin
      div_r <= div_r + DIV_W'(1);
    end
  end

  // float led sequencer for slot A: delay, then one pulse on the chosen led
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      state_r  <= fma_pkg::FMA_IDLE;
      us_r     <= 8'h00;
      led_r    <= 3'h0;
      choice_q <= 2'h0;
      width_q  <= 5'h00;
      offset_q <= 8'h00;
    end
    else
    begin
      case (state_r)
        fma_pkg::FMA_IDLE:
        begin
          if (start_a && cfg_choice != 2'h0)
          begin
            choice_q <= cfg_choice;
            width_q  <= cfg_width;
            offset_q <= cfg_offset;
            if (cfg_offset != 8'h00)
            begin
              state_r <= fma_pkg::FMA_DELAY;
              us_r    <= cfg_offset;
            end
            else if (cfg_width != 5'h00)
            begin
              state_r <= fma_pkg::FMA_PULSE;
              us_r    <= {3'h0, cfg_width};
              led_r   <= 3'h1 << (cfg_choice - 2'h1);
            end
          end
        end
        fma_pkg::FMA_DELAY:
        begin
          if (tick && us_r == 8'h01)
          begin
            if (width_q != 5'h00)
            begin
              state_r <= fma_pkg::FMA_PULSE;
              us_r    <= {3'h0, width_q};
              led_r   <= 3'h1 << (choice_q - 2'h1);
            end
            else
            begin
              state_r <= fma_pkg::FMA_IDLE;
            end
          end
          else if (tick)
          begin
            us_r <= us_r - 8'h01;
          end
        end
        fma_pkg::FMA_PULSE:
        begin
          if (tick && us_r == 8'h01)
          begin
            state_r <= fma_pkg::FMA_IDLE;
            led_r   <= 3'h0;
          end
          else if (tick)
          begin
            us_r <= us_r - 8'h01;
          end
        end
        default:
        begin
          state_r <= fma_pkg::FMA_IDLE;
          led_r   <= 3'h0;
        end
      endcase
    end
  end

  assign FLOAT_LED = led_r;

  // helper counters for timing checks
  logic [15:0] hi_cnt_r;
  logic [15:0] dly_cnt_r;

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      hi_cnt_r  <= 16'h0000;
      dly_cnt_r <= 16'h0000;
    end
    else
    begin
      hi_cnt_r  <= (led_r != 3'h0) ? hi_cnt_r + 16'h0001 : 16'h0000;
      dly_cnt_r <= (state_r == fma_pkg::FMA_DELAY) ? dly_cnt_r + 16'h0001 : 16'h0000;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  thresh_compare_a: assert property (|hit_vec |-> ADC_RESULT > (ADC_SLOT ?
      thr_b_r[fma_pkg::THR_MSB:0] : thr_a_r[fma_pkg::THR_MSB:0]))
    else $error("count bumped without exceeding threshold");
  slot_lanes_a: assert property ((|hit_vec[3:0] |-> !ADC_SLOT) and (|hit_vec[7:4] |-> ADC_SLOT))
    else $error("exceedance routed to wrong slot lane");
  status_read_a: assert property (status_rd |=> REG_RDATA == {8'h00, $past(flags)} && REG_RVALID)
    else $error("status read returned wrong flags");
  status_clear_a: assert property (status_rd && hit_vec == 8'h00 |=> flags == 8'h00)
    else $error("flags not cleared by status read");
  led_choice_a: assert property ($rose(|led_r) |-> choice_q != 2'h0
      && led_r == 3'h1 << (choice_q - 2'h1))
    else $error("wrong float led driven");
  led_width_a: assert property ($fell(|led_r) |-> hi_cnt_r == 16'(width_q) * STEP16)
    else $error("float pulse width wrong");
  led_delay_a: assert property (state_r == fma_pkg::FMA_PULSE
      && $past(state_r) == fma_pkg::FMA_DELAY |-> dly_cnt_r == 16'(offset_q) * STEP16)
    else $error("delay to first float pulse wrong");

  read_clear_cover: cover property (status_rd && flags != 8'h00);
  slot_b_cover: cover property ($rose(|flags[7:4]));
  led_pulse_cover: cover property ($fell(|led_r) && offset_q != 8'h00);

endmodule

/* File: tb/fma_host.sv */
// host-side register access model for the ambient monitor
module fma_host (
  input  wire logic        clk,
  output logic      [7:0]  addr,
  output logic      [15:0] wdata,
  output logic             wr,
  output logic             rd,
  input  wire logic [15:0] rdata,
  input  wire logic        rvalid
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus at time zero
  initial
  begin
    addr = 8'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
  end

  // one write strobe; the reserved led config bit is always sent as zero
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= (a == fma_pkg::ADDR_LED_A) ? (d & 16'hdfff) : d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // one read strobe, answer awaited for a bounded number of edges
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    int n;
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    for (n = 0; n < 4; n++)
    begin
      @(posedge clk);
      if (rvalid === 1'b1)
        break;
    end
    d = (rvalid === 1'b1) ? rdata : 16'hdead;
  endtask
endmodule

/* File: tb/fma_top_tb.sv */
// self-checking bench for the float-mode ambient monitor
module fma_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;
  logic        srst;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        reg_rvalid;
  logic        adc_valid;
  logic [13:0] adc_result;
  logic        adc_slot;
  logic [1:0]  adc_chan;
  logic        float_sub;
  logic        slot_start;
  logic        slot_id;
  logic [2:0]  float_led;
  int          fail_count = 0;
  int          n_compared = 0;
  int          cyc = 0;
  logic [31:0] seed = 32'h93a45921;

  fma_top u_dut (
    .CLK(clk), .SRST(srst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid),
    .ADC_VALID(adc_valid), .ADC_RESULT(adc_result), .ADC_SLOT(adc_slot),
    .ADC_CHAN(adc_chan), .FLOAT_SUB(float_sub), .SLOT_START(slot_start),
    .SLOT_ID(slot_id), .FLOAT_LED(float_led)
  );

  fma_host u_host (
    .clk(clk), .addr(reg_addr), .wdata(reg_wdata), .wr(reg_wr), .rd(reg_rd),
    .rdata(reg_rdata), .rvalid(reg_rvalid)
  );

  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // count of exceedances that sets a flag for a count code
  function automatic int hits_for(input logic [1:0] code);
    return (code == 2'h0) ? 0 : (code == 2'h1) ? 1 : (code == 2'h2) ? 4 : 16;
  endfunction

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // one adc result presented for one cycle
  task automatic hit(input logic s, input logic [1:0] c, input logic [13:0] r, input logic f);
    @(posedge clk);
    adc_valid <= 1'b1;
    adc_slot <= s;
    adc_chan <= c;
    adc_result <= r;
    float_sub <= f;
    @(posedge clk);
    adc_valid <= 1'b0;
  endtask

  // results equal to threshold or outside subtract cycles, then n real exceedances
  task automatic burst(input logic s, input logic [1:0] c, input logic [13:0] t, input int n);
    hit(s, c, t, 1'b1);
    hit(s, c, 14'h3fff, 1'b0);
    for (int i = 0; i < n; i++)
      hit(s, c, 14'h3fff, 1'b1);
  endtask

  task automatic start(input logic id);
    @(posedge clk);
    slot_start <= 1'b1;
    slot_id <= id;
    @(posedge clk);
    slot_start <= 1'b0;
  endtask

  // cycle ceiling against hangs
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      fail_count++;
      tally_and_finish();
    end
  end

  // main sequence
  initial
  begin
    logic [15:0] got;
    logic [13:0] thr;
    logic [1:0]  ch;
    logic [7:0]  ta;
    logic [4:0]  w;
    logic [7:0]  o;
    int          n;
    int          d;
    srst = 1'b1;
    adc_valid = 1'b0;
    adc_result = 14'h0000;
    adc_slot = 1'b0;
    adc_chan = 2'h0;
    float_sub = 1'b0;
    slot_start = 1'b0;
    slot_id = 1'b0;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    u_host.rd_reg(fma_pkg::ADDR_THR_A, got);
    chk(got, 16'h0000);
    u_host.rd_reg(fma_pkg::ADDR_THR_B, got);
    chk(got, 16'h0000);
    u_host.rd_reg(fma_pkg::ADDR_LED_A, got);
    chk(got, 16'h0320);
    u_host.wr_reg(fma_pkg::ADDR_STATUS, 16'h00ff);
    u_host.rd_reg(fma_pkg::ADDR_STATUS, got);
    chk(got, 16'h0000);
    u_host.rd_reg(8'h10, got);
    chk(got, 16'h0000);
    $display("test reset values done");
    for (int s = 0; s < 2; s++)
    begin
      for (int code = 0; code < 4; code++)
      begin
        thr = $random(seed) & 14'h3ffe;
        ch = $random(seed);
        ta = s ? fma_pkg::ADDR_THR_B : fma_pkg::ADDR_THR_A;
        n = hits_for(code[1:0]);
        u_host.wr_reg(ta, {code[1:0], thr});
        u_host.rd_reg(ta, got);
        chk(got, {code[1:0], thr});
        burst(s[0], ch, thr, (n > 0) ? n - 1 : 16);
        u_host.rd_reg(fma_pkg::ADDR_STATUS, got);
        chk(got & 16'h00ff, 16'h0000);
        if (n > 1)
        begin
          burst(s[0], ch, thr, n - 1);
          u_host.rd_reg(fma_pkg::ADDR_STATUS, got);
          chk(got & 16'h00ff, 16'h0000);
        end
        if (n > 0)
        begin
          burst(s[0], ch, thr, n);
          u_host.rd_reg(fma_pkg::ADDR_STATUS, got);
          chk(got & 16'h00ff, 16'h0001 << (s * 4 + ch));
          u_host.rd_reg(fma_pkg::ADDR_STATUS, got);
          chk(got & 16'h00ff, 16'h0000);
        end
      end
    end
    $display("test exceed counting done");
    for (int c = 0; c < 4; c++)
    begin
      w = 5'h01 + 5'($random(seed) & 1);
      o = (c == 1) ? 8'h00 : 8'h01 + 8'($random(seed) & 2); // offset 0 corner, else 1 or 3
      u_host.wr_reg(fma_pkg::ADDR_LED_A, {c[1:0], 1'b0, w, o});
      u_host.rd_reg(fma_pkg::ADDR_LED_A, got);
      chk(got, {c[1:0], 1'b0, w, o});
      start(1'b1);
      start(1'b0);
      // d counts edges after the start edge until the led shows
      #1;
      for (d = 0; d < 700 && float_led === 3'h0; d++)
      begin
        @(posedge clk);
        #1;
      end
      chk(d, (c == 0) ? 700 : o * fma_pkg::STEP_CYCLES);
      chk({13'h0, float_led}, (c == 0) ? 16'h0 : 16'h1 << (c - 1));
      for (n = 0; n < 1000 && float_led !== 3'h0; n++)
        @(posedge clk) #1;
      chk(n, (c == 0) ? 0 : w * fma_pkg::STEP_CYCLES);
    end
    $display("test float led done");
    tally_and_finish();
  end
endmodule
